// ### sbf_flags.sv
// Serial bus mode control and status flags with APB register access
`timescale 1ns/1ps
//
// Behaviour
// R1 - Acknowledge trigger drives ack at next clock fall
// R2 - Acknowledge trigger cleared by transfer start, disable
// R3 - Command condition sets command detected flag
// R4 - Command flag cleared: start, release, disable, reset
// R5 - Release condition sets release detected flag
// R6 - Release flag cleared: start, mismatch, disable, reset
// R7 - Command trigger clears output latch, self-clears
// R8 - Release trigger sets output latch, self-clears
// R9 - Trigger bits always read back as zero
// R10 - Clock level bit mirrors pin, zero when disabled
// R11 - Cause select adds release detection to interrupt
// R12 - Width select drops address bit zero
// R13 - Software keeps cause select zero for wake-up
// R14 - Software writes zero to timing bits 0-3
// R15 - Software sets ack trigger only after transfer
// R16 - Timing register resets to zero, byte writable
// R17 - Release: data rises while clock high
// R18 - Command: data falls while clock high
// R19 - Automatic ack on ninth clock fall
// R20 - Lines sampled and flags kept on pclk
module sbf_flags
(
  input wire logic pclk, // System clock, 100 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic serial_clock_pin, // Serial clock pin level
  input wire logic bus_data_line_in, // Serial data line level
  output logic bus_data_line_out, // Serial data line drive value
  output logic bus_data_line_oe, // Open-drain pull-low enable
  output logic channel_interrupt // One-cycle channel interrupt pulse
);

  sbf_pkg::sbf_state_type s_q;
  sbf_pkg::sbf_state_type s_d;
  sbf_pkg::sbf_lines_type raw;
  sbf_pkg::sbf_lines_type lines;
  logic [sbf_pkg::ADDR_W-1:0] addr;
  logic hit;
  logic setup;
  logic wr;
  logic [7:0] wb;
  logic clk_rise;
  logic clk_fall;
  logic rel_cond;
  logic cmd_cond;
  logic start_xfer;
  logic xfer_end;
  logic addr_mismatch;
  logic [7:0] cmp_mask;

  // Pin levels pass two flip-flops before use
  assign raw.sclk = serial_clock_pin;
  assign raw.sdata = bus_data_line_in;

  sbf_sync u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .raw(raw),
    .synced(lines)
  );

  // APB decode; zero wait states
  assign addr = paddr[sbf_pkg::ADDR_W-1:0];
  assign hit = (paddr[31:sbf_pkg::ADDR_W] == '0) &&
    (addr == sbf_pkg::SHIFT_REGISTER_ADDR || addr == sbf_pkg::SERIAL_BUS_CONTROL_ADDR ||
    addr == sbf_pkg::SLAVE_ADDRESS_REG_ADDR || addr == sbf_pkg::SERIAL_INTERRUPT_TIMING_ADDR ||
    addr == sbf_pkg::CHANNEL_MODE_REG_ADDR);
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && pstrb[0] && hit;
  assign wb = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = s_q.prdata;

  // Bus condition detection on sampled lines
  assign clk_rise = lines.sclk && !s_q.prev.sclk; // [R20]
  assign clk_fall = !lines.sclk && s_q.prev.sclk; // [R20]
  assign rel_cond = s_q.channel_enable && lines.sclk && s_q.prev.sclk &&
    lines.sdata && !s_q.prev.sdata; // [R17]
  assign cmd_cond = s_q.channel_enable && lines.sclk && s_q.prev.sclk &&
    !lines.sdata && s_q.prev.sdata; // [R18]

  // Transfer start is a write of the shift register
  assign start_xfer = wr && addr == sbf_pkg::SHIFT_REGISTER_ADDR && s_q.channel_enable;
  assign xfer_end = s_q.xfer_active && clk_rise && s_q.rise_cnt == sbf_pkg::BITS_PER_BYTE - 4'h1;

  // Address compare on the byte that follows a release and then a command
  assign cmp_mask = s_q.addr_width_select ? 8'hFE : 8'hFF; // [R12]
  assign addr_mismatch = xfer_end && s_q.release_detected && s_q.command_detected &&
    ((({s_q.shift_data[6:0], lines.sdata} ^ s_q.slave_address) & cmp_mask) != 8'h00); // [R12]

  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.prev = lines;
    s_d.irq = 1'b0;

    // Register writes
    if (wr)
    begin
      unique case (addr)
        sbf_pkg::SERIAL_BUS_CONTROL_ADDR:
        begin
          s_d.busy_enable = wb[sbf_pkg::BUSY_ENABLE_BIT];
          s_d.auto_ack_enable = wb[sbf_pkg::AUTO_ACK_ENABLE_BIT];
          if (wb[sbf_pkg::ACK_TRIGGER_BIT] && s_q.channel_enable)
            s_d.ack_trigger = 1'b1;
          if (wb[sbf_pkg::COMMAND_TRIGGER_BIT] && s_q.channel_enable)
            s_d.so_latch = 1'b0; // [R7]
          if (wb[sbf_pkg::RELEASE_TRIGGER_BIT] && s_q.channel_enable)
            s_d.so_latch = 1'b1; // [R8]
        end
        sbf_pkg::SERIAL_INTERRUPT_TIMING_ADDR:
        begin
          s_d.irq_cause_select = wb[sbf_pkg::IRQ_CAUSE_SELECT_BIT]; // [R16]
          s_d.addr_width_select = wb[sbf_pkg::ADDR_WIDTH_SELECT_BIT]; // [R16]
        end
        sbf_pkg::SLAVE_ADDRESS_REG_ADDR:
          s_d.slave_address = wb;
        sbf_pkg::CHANNEL_MODE_REG_ADDR:
          s_d.channel_enable = wb[sbf_pkg::CHANNEL_ENABLE_BIT];
        default:
          s_d.shift_data = s_d.shift_data;
      endcase
    end

    // Transfer start clears flags, triggers and counters
    if (start_xfer)
    begin
      s_d.shift_data = wb;
      s_d.xfer_active = 1'b1;
      s_d.rise_cnt = 4'h0;
      s_d.fall_cnt = 4'h0;
      s_d.ack_trigger = 1'b0; // [R2]
      s_d.command_detected = 1'b0; // [R4]
      s_d.release_detected = 1'b0; // [R6]
      s_d.ack_detected = 1'b0;
    end

    // Receive shift on rising clock edges
    if (s_q.xfer_active && clk_rise)
    begin
      s_d.shift_data = {s_q.shift_data[6:0], lines.sdata};
      s_d.rise_cnt = s_q.rise_cnt + 4'h1;
    end
    if (xfer_end)
    begin
      s_d.xfer_active = 1'b0;
      s_d.irq = 1'b1; // [R11]
    end
    if (addr_mismatch)
      s_d.release_detected = 1'b0; // [R6]

    // Ack sampled at the ninth rising edge
    if (!s_q.xfer_active && clk_rise && s_q.rise_cnt == sbf_pkg::BITS_PER_BYTE)
    begin
      s_d.ack_detected = !lines.sdata;
      s_d.rise_cnt = 4'h0;
    end

    // Falling edges: ack drive windows
    if (clk_fall)
    begin
      if (s_q.ack_drive)
        s_d.ack_drive = 1'b0;
      else if (s_q.ack_trigger && !s_q.xfer_active)
      begin
        s_d.ack_drive = 1'b1; // [R1]
        s_d.ack_trigger = 1'b0; // [R1]
      end
      else if (s_q.fall_cnt == sbf_pkg::BITS_PER_BYTE && s_q.auto_ack_enable)
        s_d.ack_drive = 1'b1; // [R19]
      if (s_q.fall_cnt != sbf_pkg::BITS_PER_BYTE + 4'h1 && s_q.rise_cnt != 4'h0)
        s_d.fall_cnt = s_q.fall_cnt + 4'h1;
      else if (!s_q.xfer_active)
        s_d.fall_cnt = 4'h0;
    end
    if (start_xfer)
      s_d.fall_cnt = 4'h0;

    // Release condition: set wins over a same-cycle start or mismatch clear, but disable still clears it
    if (rel_cond)
    begin
      s_d.release_detected = 1'b1; // [R5]
      s_d.command_detected = 1'b0; // [R4]
      if (s_q.irq_cause_select)
        s_d.irq = 1'b1; // [R11]
    end
    if (cmd_cond)
      s_d.command_detected = 1'b1; // [R3]

    // Disabled channel forces flags and triggers low
    if (!s_d.channel_enable)
    begin
      s_d.ack_trigger = 1'b0; // [R2]
      s_d.command_detected = 1'b0; // [R4]
      s_d.release_detected = 1'b0; // [R6]
      s_d.ack_detected = 1'b0;
      s_d.ack_drive = 1'b0;
      s_d.xfer_active = 1'b0;
    end

    // Read data captured in the setup phase
    s_d.prdata = 32'h0000_0000;
    if (setup && !pwrite)
    begin
      unique case (addr)
        sbf_pkg::SERIAL_BUS_CONTROL_ADDR:
        begin
          s_d.prdata[sbf_pkg::BUSY_ENABLE_BIT] = s_q.busy_enable;
          s_d.prdata[sbf_pkg::ACK_DETECTED_BIT] = s_q.ack_detected;
          s_d.prdata[sbf_pkg::AUTO_ACK_ENABLE_BIT] = s_q.auto_ack_enable;
          s_d.prdata[sbf_pkg::COMMAND_DETECTED_BIT] = s_q.command_detected;
          s_d.prdata[sbf_pkg::RELEASE_DETECTED_BIT] = s_q.release_detected;
        end
        sbf_pkg::SERIAL_INTERRUPT_TIMING_ADDR:
        begin
          s_d.prdata[sbf_pkg::CLOCK_LEVEL_BIT] = lines.sclk && s_q.channel_enable; // [R10]
          s_d.prdata[sbf_pkg::IRQ_CAUSE_SELECT_BIT] = s_q.irq_cause_select;
          s_d.prdata[sbf_pkg::ADDR_WIDTH_SELECT_BIT] = s_q.addr_width_select;
        end
        sbf_pkg::SLAVE_ADDRESS_REG_ADDR:
          s_d.prdata[7:0] = s_q.slave_address;
        sbf_pkg::SHIFT_REGISTER_ADDR:
          s_d.prdata[7:0] = s_q.shift_data;
        sbf_pkg::CHANNEL_MODE_REG_ADDR:
          s_d.prdata[sbf_pkg::CHANNEL_ENABLE_BIT] = s_q.channel_enable;
        default:
          s_d.prdata = 32'h0000_0000;
      endcase
    end
  end

  // Trigger bits are never placed in read data, so reads return zero [R9]
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0; // [R16]
      s_q.so_latch <= 1'b1;
      s_q.prev <= '1;
    end
    else
      s_q <= s_d;
  end

  // Open-drain data line: pull low for latch zero or ack
  assign bus_data_line_out = 1'b0;
  assign bus_data_line_oe = !s_q.so_latch || s_q.ack_drive;
  assign channel_interrupt = s_q.irq;

endmodule : sbf_flags

// ### sbf_pkg.sv
// Package with register map, field positions and state layout of the serial bus flag block
package sbf_pkg;

  // Register indices; byte address is four times the index
  localparam int unsigned SHIFT_REGISTER_IDX = 32'h0000_FF60;
  localparam int unsigned SERIAL_BUS_CONTROL_IDX = 32'h0000_FF61;
  localparam int unsigned SLAVE_ADDRESS_REG_IDX = 32'h0000_FF62;
  localparam int unsigned SERIAL_INTERRUPT_TIMING_IDX = 32'h0000_FF63;
  localparam int unsigned CHANNEL_MODE_REG_IDX = 32'h0000_FF65;

  localparam int unsigned ADDR_W = 18;
  localparam logic [ADDR_W-1:0] SHIFT_REGISTER_ADDR = ADDR_W'(SHIFT_REGISTER_IDX * 4);
  localparam logic [ADDR_W-1:0] SERIAL_BUS_CONTROL_ADDR = ADDR_W'(SERIAL_BUS_CONTROL_IDX * 4);
  localparam logic [ADDR_W-1:0] SLAVE_ADDRESS_REG_ADDR = ADDR_W'(SLAVE_ADDRESS_REG_IDX * 4);
  localparam logic [ADDR_W-1:0] SERIAL_INTERRUPT_TIMING_ADDR =
    ADDR_W'(SERIAL_INTERRUPT_TIMING_IDX * 4);
  localparam logic [ADDR_W-1:0] CHANNEL_MODE_REG_ADDR = ADDR_W'(CHANNEL_MODE_REG_IDX * 4);

  // Control register bit positions
  localparam int unsigned RELEASE_TRIGGER_BIT = 0;
  localparam int unsigned COMMAND_TRIGGER_BIT = 1;
  localparam int unsigned RELEASE_DETECTED_BIT = 2;
  localparam int unsigned COMMAND_DETECTED_BIT = 3;
  localparam int unsigned ACK_TRIGGER_BIT = 4;
  localparam int unsigned AUTO_ACK_ENABLE_BIT = 5;
  localparam int unsigned ACK_DETECTED_BIT = 6;
  localparam int unsigned BUSY_ENABLE_BIT = 7;

  // Interrupt timing register bit positions
  localparam int unsigned ADDR_WIDTH_SELECT_BIT = 4;
  localparam int unsigned IRQ_CAUSE_SELECT_BIT = 5;
  localparam int unsigned CLOCK_LEVEL_BIT = 6;

  // Mode register bit position
  localparam int unsigned CHANNEL_ENABLE_BIT = 7;

  // Reset values and counts
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int unsigned SYNC_STAGES = 2;

  // Synchronised bus line levels
  typedef struct packed {
    logic sclk;
    logic sdata;
  } sbf_lines_type;

  // Whole state of the flag block
  typedef struct packed {
    logic channel_enable;
    logic busy_enable;
    logic auto_ack_enable;
    logic ack_trigger;
    logic ack_detected;
    logic command_detected;
    logic release_detected;
    logic irq_cause_select;
    logic addr_width_select;
    logic [7:0] slave_address;
    logic [7:0] shift_data;
    logic so_latch;
    logic ack_drive;
    logic xfer_active;
    logic [3:0] rise_cnt;
    logic [3:0] fall_cnt;
    sbf_lines_type prev;
    logic irq;
    logic [31:0] prdata;
  } sbf_state_type;

endpackage : sbf_pkg

// ### sbf_sync.sv
// Two flip-flop synchroniser for the bus line levels
`timescale 1ns/1ps
module sbf_sync
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire sbf_pkg::sbf_lines_type raw, // Unsynchronised pin levels
  output sbf_pkg::sbf_lines_type synced // Levels after two stages
);

  sbf_pkg::sbf_lines_type meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Lines idle high on the pull-up, so no false edge follows reset
      meta_q <= '1;
      synced <= '1;
    end
    else
    begin
      meta_q <= raw;
      synced <= meta_q;
    end
  end

endmodule : sbf_sync

// ### sbf_flags_checker.sv
// Port checks for the serial bus flag block
`timescale 1ns/1ps
module sbf_flags_checker
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Access phase
  input wire logic pwrite, // Direction
  input wire logic [31:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [3:0] pstrb, // Strobes
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic serial_clock_pin, // Clock pin
  input wire logic bus_data_line_in, // Data line
  input wire logic bus_data_line_out, // Data drive
  input wire logic bus_data_line_oe, // Pull-low
  input wire logic channel_interrupt // Interrupt
);
  localparam logic [31:0] ctl_addr = 32'(sbf_pkg::SERIAL_BUS_CONTROL_ADDR);
  localparam logic [31:0] tim_addr = 32'(sbf_pkg::SERIAL_INTERRUPT_TIMING_ADDR);
  localparam logic [31:0] mode_addr = 32'(sbf_pkg::CHANNEL_MODE_REG_ADDR);
  logic en_q; // Channel enable as last written
  logic acc; // Access phase
  assign acc = psel && penable;
  // Follow channel enable writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_q <= 1'b0;
    else if (acc && pwrite && pstrb[0] && paddr == mode_addr)
      en_q <= pwdata[7];
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Read of one register
  sequence s_rd(a);
    acc && !pwrite && paddr == a;
  endsequence
  // Enabled control write
  sequence s_wr_ctl;
    acc && pwrite && pstrb[0] && en_q && paddr == ctl_addr;
  endsequence
  AST_RD_TRIG: assert property (s_rd(ctl_addr) |-> prdata[1:0] == 2'h0 && !prdata[4])
    else $error("trigger bit reads one");
  AST_RD_HIGH: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  AST_TIM_LOW: assert property (s_rd(tim_addr) |-> !prdata[7] && prdata[3:0] == 4'h0)
    else $error("fixed timing bits set");
  AST_CLD: assert property ($stable(serial_clock_pin)[*6] ##0 s_rd(tim_addr) |->
    prdata[6] == (en_q && serial_clock_pin)) else $error("clock level wrong");
  AST_IRQ_ONE: assert property (channel_interrupt |=> !channel_interrupt)
    else $error("interrupt longer than one cycle");
  AST_IRQ_OFF: assert property (!en_q [*2] |-> !channel_interrupt)
    else $error("interrupt while disabled");
  AST_CMD_TRIG: assert property (s_wr_ctl ##0 pwdata[1] |-> ##[1:4] bus_data_line_oe)
    else $error("command trigger left latch high");
  AST_REL_TRIG: assert property (s_wr_ctl ##0 pwdata[4:0] == 5'h01 |-> ##[1:4] !bus_data_line_oe)
    else $error("release trigger left latch low");
endmodule : sbf_flags_checker

// ### sbf_node_model.sv
// Far-side bus master driving the clock and data lines
`timescale 1ns/1ps
module sbf_node_model
(
  input wire logic oe, // Device pull-low enable
  output logic scl, // Clock line, 80 ns period in frames
  output logic sda // Data line with pull-up
);
  logic drv = 1'b1; // Own drive, high releases
  initial scl = 1'b1;
  // Open-drain wired-and with pull-up
  assign sda = drv & ~oe;
  // Data falls while clock high
  task automatic command_cond();
    scl = 1'b0;
    drv = 1'b1;
    #40 scl = 1'b1;
    #40 drv = 1'b0;
    #40 scl = 1'b0;
  endtask : command_cond
  // Eight bits, high bit first, data moves only while clock low
  task automatic send_byte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
    begin
      scl = 1'b0;
      drv = d[i];
      #40 scl = 1'b1;
      #40;
    end
  endtask : send_byte
  // Clock fall for an acknowledge slot, then clock stands low
  task automatic lower_clock();
    #40 scl = 1'b0;
    #40;
  endtask : lower_clock
endmodule : sbf_node_model

// ### sbf_flags_test.sv
// Self-checking bench for the serial bus flag block
`timescale 1ns/1ps
module sbf_flags_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic serial_clock_pin, bus_data_line_in, bus_data_line_out, bus_data_line_oe;
  logic channel_interrupt;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [3:0] pstrb;
  int mismatches, tests_run, irqs;
  localparam logic [17:0] CTL = sbf_pkg::SERIAL_BUS_CONTROL_ADDR;
  localparam logic [17:0] TIM = sbf_pkg::SERIAL_INTERRUPT_TIMING_ADDR;
  localparam logic [17:0] MODE = sbf_pkg::CHANNEL_MODE_REG_ADDR;
  localparam logic [17:0] SHIFT = sbf_pkg::SHIFT_REGISTER_ADDR;
  sbf_flags sbf_flags_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .serial_clock_pin, .bus_data_line_in,
    .bus_data_line_out, .bus_data_line_oe, .channel_interrupt);
  sbf_node_model sbf_node_model_inst (.oe(bus_data_line_oe), .scl(serial_clock_pin),
    .sda(bus_data_line_in));
  // Clock generator
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Count interrupt pulses
  always @(posedge pclk)
    if (channel_interrupt === 1'b1)
      irqs <= irqs + 1;
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, result left in r and e
  task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= 32'(a);
    pwdata <= 32'(d);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge pclk);
    mismatches += int'(n == 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [17:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(r, 32'(x));
  endtask : rd
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'h1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(TIM, 8'h00);
    rd(CTL, 8'h00);
    apb(1'b0, 18'h0_0004, 8'h00);
    chk(32'(e), 32'h0000_0001);
    apb(1'b1, MODE, 8'h80);
    apb(1'b1, TIM, 8'h30);
    rd(TIM, 8'h70);
    $display("test registers done");
    apb(1'b1, CTL, 8'h02);
    repeat (6) @(posedge pclk);
    chk(32'(bus_data_line_oe), 32'h0000_0001);
    rd(CTL, 8'h08);
    apb(1'b1, CTL, 8'h01);
    repeat (6) @(posedge pclk);
    chk(32'(bus_data_line_oe), 32'h0000_0000);
    rd(CTL, 8'h04);
    chk(32'(irqs), 32'h0000_0001);
    sbf_node_model_inst.command_cond();
    repeat (6) @(posedge pclk);
    rd(CTL, 8'h0C);
    $display("test conditions done");
    apb(1'b1, SHIFT, 8'hFF);
    rd(CTL, 8'h00);
    sbf_node_model_inst.send_byte(8'hA5);
    repeat (6) @(posedge pclk);
    chk(32'(irqs), 32'h0000_0002);
    rd(SHIFT, 8'hA5);
    $display("test transfer done");
    apb(1'b1, CTL, 8'h10);
    sbf_node_model_inst.lower_clock();
    chk(32'(bus_data_line_oe), 32'h0000_0001);
    rd(CTL, 8'h00);
    $display("test acknowledge done");
    apb(1'b1, MODE, 8'h00);
    rd(TIM, 8'h30);
    rd(CTL, 8'h00);
    apb(1'b1, CTL, 8'h02);
    repeat (6) @(posedge pclk);
    chk(32'(bus_data_line_oe), 32'h0000_0000);
    chk(32'(bus_data_line_out), 32'h0000_0000);
    apb(1'b1, TIM, 8'h00);
    rd(TIM, 8'h00);
    $display("test disable done");
    end_sim();
  end
endmodule : sbf_flags_test
bind sbf_flags sbf_flags_checker sbf_flags_checker_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .serial_clock_pin,
  .bus_data_line_in, .bus_data_line_out, .bus_data_line_oe, .channel_interrupt);
